// *** core/sync_interval_meter.sv ***
// Measures start-to-stop intervals in nanoseconds and keeps the largest one.
// Assumes one-cycle start and stop pulses on the core clock.
`default_nettype none
`include "sync_map.svh"
module sync_interval_meter (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  input wire logic enable,
  input wire logic clear,
  output logic [31:0] maxNs
);
  logic running_q;
  logic [31:0] elapsed_q;
  logic [31:0] max_q;
  assign maxNs = max_q;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      running_q <= 1'b0;
      elapsed_q <= 32'h0000_0000;
    end
    else if (start)
    begin
      running_q <= 1'b1;
      elapsed_q <= `CLK_PERIOD_NS;
    end
    else if (stop)
      running_q <= 1'b0;
    else if (running_q && elapsed_q <= `NS_SAT_LIMIT)
      elapsed_q <= elapsed_q + `CLK_PERIOD_NS;
  end
  // A stop without a start in flight is ignored, so stray strobes never inflate the maximum.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      max_q <= 32'h0000_0000;
    else if (clear)
      max_q <= 32'h0000_0000;
    else if (enable && stop && !start && running_q && elapsed_q > max_q)
      max_q <= elapsed_q;
  end
  chk_clear_zeroes: assert property (@(posedge core_clk) disable iff (rst)
    clear |=> maxNs == 32'h0000_0000)
    else $error("maximum not cleared");
  chk_idle_holds: assert property (@(posedge core_clk) disable iff (rst)
    (!enable && !clear) |=> $stable(maxNs))
    else $error("maximum moved while not measuring");
endmodule
`default_nettype wire

// *** core/sync_manager_output_timing.sv ***
// Output sync-manager parameter bank with cycle timing measurement and error counters.
// Assumes AXI4-Lite masters and event strobes that are synchronous to core_clk.
//
// Design decisions made here: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
`include "sync_map.svh"
// Contract
// - Sync mode 0 free run, 1 sync-manager event.
// - Cycle time sets local or master period.
// - Report SYNC0-to-output shift time, DC only.
// - Supported-modes word reads 0x4001.
// - Command 1 starts, 0 stops measurement.
// - Measured fields keep largest observed values.
// - New measurement clears previously held maxima.
// - Report SYNC1-to-output delay time, DC only.
// - Report needed SYNC0-to-SYNC1 spacing, DC only; the minimum delay register reads 0 here in every mode.
// - Count missed events in operational DC mode.
// - Count late cycles or early next cycles.
// - Count too-short SYNC0-to-SYNC1 spacings.
// - Flag outputs driven too late last cycle.
// - Four sync manager channels typed 1-4.
// - Receive assignment holds 0x1603 and 0x1607.
// - Transmit assignment holds 0x1A00 to 0x1A03.
// - Time-stamp mapping holds one 64-bit entry.
// - Report shortest supported cycle, read only.
// - Mode codes 0, 1, 2, 3 and 34.
module sync_manager_output_timing (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire sync_pkg::timing_evt_s timingEv,
  output logic cycleTick,
  output logic syncError
);
  logic awReady_q;
  logic wReady_q;
  logic awHave_q;
  logic wHave_q;
  logic [11:0] awAddr_q;
  logic [31:0] wData_q;
  logic [3:0] wStrb_q;
  logic bValid_q;
  logic [1:0] bResp_q;
  logic arReady_q;
  logic rValid_q;
  logic [31:0] rData_q;
  logic [1:0] rResp_q;
  logic [15:0] mode_q;
  logic [31:0] cycleTime_q;
  logic [15:0] cmd_q;
  logic measuring_q;
  logic [31:0] localNs_q;
  logic tick_q;
  logic smSeen_q;
  logic busy_q;
  logic pendDrive_q;
  logic syncErr_q;
  logic [31:0] s0s1Ns_q;
  logic [15:0] errCnt_q [3];
  logic doWrite;
  logic wrMode;
  logic wrCycle;
  logic wrCmd;
  logic wrOk;
  logic [31:0] modeNew;
  logic [31:0] cycleNew;
  logic [31:0] cmdNew;
  logic modeLegal;
  logic startMeas;
  logic dcMode;
  logic cycleStart;
  logic [2:0] errEv;
  logic [3:0] mStart;
  logic [3:0] mStop;
  logic [3:0] mEn;
  logic [31:0] meterNs [4];
  logic [31:0] rdData;
  logic rdOk;

  function automatic logic [31:0] mergeStrb(
    input logic [31:0] oldV,
    input logic [31:0] newV,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = oldV;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        res[8*i +: 8] = newV[8*i +: 8];
    end
    return res;
  endfunction

  assign s_axi_awready = awReady_q;
  assign s_axi_wready = wReady_q;
  assign s_axi_bvalid = bValid_q;
  assign s_axi_bresp = bResp_q;
  assign s_axi_arready = arReady_q;
  assign s_axi_rvalid = rValid_q;
  assign s_axi_rdata = rData_q;
  assign s_axi_rresp = rResp_q;
  assign cycleTick = tick_q;
  assign syncError = syncErr_q;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      awReady_q <= 1'b1;
      awHave_q <= 1'b0;
      awAddr_q <= 12'h000;
    end
    else if (s_axi_awvalid && awReady_q)
    begin
      awReady_q <= 1'b0;
      awHave_q <= 1'b1;
      awAddr_q <= {s_axi_awaddr[11:2], 2'h0};
    end
    else if (bValid_q && s_axi_bready)
    begin
      awReady_q <= 1'b1;
      awHave_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wReady_q <= 1'b1;
      wHave_q <= 1'b0;
      wData_q <= 32'h0000_0000;
      wStrb_q <= 4'h0;
    end
    else if (s_axi_wvalid && wReady_q)
    begin
      wReady_q <= 1'b0;
      wHave_q <= 1'b1;
      wData_q <= s_axi_wdata;
      wStrb_q <= s_axi_wstrb;
    end
    else if (bValid_q && s_axi_bready)
    begin
      wReady_q <= 1'b1;
      wHave_q <= 1'b0;
    end
  end

  assign doWrite = awHave_q && wHave_q && !bValid_q;
  assign modeNew = mergeStrb({16'h0000, mode_q}, wData_q, wStrb_q);
  assign cycleNew = mergeStrb(cycleTime_q, wData_q, wStrb_q);
  assign cmdNew = mergeStrb({16'h0000, cmd_q}, wData_q, wStrb_q);

  // Only the documented mode codes are stored; anything else leaves the mode untouched.
  always_comb
  begin
    unique case (modeNew[15:0])
      sync_pkg::MODE_FREE,
      sync_pkg::MODE_SM,
      sync_pkg::MODE_DC_S0,
      sync_pkg::MODE_DC_S1,
      sync_pkg::MODE_SM_OUT: modeLegal = 1'b1;
      default: modeLegal = 1'b0;
    endcase
  end

  always_comb
  begin
    wrMode = 1'b0;
    wrCycle = 1'b0;
    wrCmd = 1'b0;
    wrOk = 1'b0;
    if (doWrite)
    begin
      unique case (awAddr_q)
        `OFF_SYNC_MODE:
        begin
          wrMode = 1'b1;
          wrOk = 1'b1;
        end
        `OFF_CYCLE_TIME:
        begin
          wrCycle = 1'b1;
          wrOk = 1'b1;
        end
        `OFF_MEAS_CMD:
        begin
          wrCmd = 1'b1;
          wrOk = 1'b1;
        end
        default: wrOk = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      bValid_q <= 1'b0;
      bResp_q <= `RESP_OKAY;
    end
    else if (doWrite)
    begin
      bValid_q <= 1'b1;
      bResp_q <= wrOk ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      bValid_q <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      mode_q <= `RST_SYNC_MODE;
    else if (wrMode && modeLegal)
      mode_q <= modeNew[15:0];
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      cycleTime_q <= `RST_CYCLE_TIME;
    else if (wrCycle)
      cycleTime_q <= cycleNew;
  end

  // Rewriting 1 while a run is active keeps the maxima; only a fresh start clears them.
  assign startMeas = wrCmd && cmdNew[`CMD_START_BIT] && !measuring_q;
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_q <= `RST_MEAS_CMD;
      measuring_q <= 1'b0;
    end
    else if (wrCmd)
    begin
      cmd_q <= cmdNew[15:0];
      measuring_q <= cmdNew[`CMD_START_BIT];
    end
  end

  // Free-run timer counts in nanoseconds, so no divider is needed for the period.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      localNs_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else if (mode_q != sync_pkg::MODE_FREE || cycleTime_q == 32'h0000_0000)
    begin
      localNs_q <= 32'h0000_0000;
      tick_q <= 1'b0;
    end
    else if (localNs_q + `CLK_PERIOD_NS >= cycleTime_q)
    begin
      localNs_q <= 32'h0000_0000;
      tick_q <= 1'b1;
    end
    else
    begin
      localNs_q <= localNs_q + `CLK_PERIOD_NS;
      tick_q <= 1'b0;
    end
  end

  assign dcMode = mode_q == sync_pkg::MODE_DC_S0 || mode_q == sync_pkg::MODE_DC_S1;
  always_comb
  begin
    if (dcMode)
      cycleStart = timingEv.sync0;
    else if (mode_q == sync_pkg::MODE_FREE)
      cycleStart = tick_q;
    else
      cycleStart = timingEv.smEvent;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      smSeen_q <= 1'b0;
    else if (timingEv.sync0)
      smSeen_q <= 1'b0;
    else if (timingEv.smEvent)
      smSeen_q <= 1'b1;
  end

  // A cycle start and a done in the same cycle close the old cycle and open a new one.
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      busy_q <= 1'b0;
    else if (cycleStart)
      busy_q <= 1'b1;
    else if (timingEv.cycleDone)
      busy_q <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      s0s1Ns_q <= 32'h0000_0000;
    else if (timingEv.sync0)
      s0s1Ns_q <= `CLK_PERIOD_NS;
    else if (s0s1Ns_q <= `NS_SAT_LIMIT)
      s0s1Ns_q <= s0s1Ns_q + `CLK_PERIOD_NS;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      pendDrive_q <= 1'b0;
    else if (timingEv.sync0)
      pendDrive_q <= 1'b1;
    else if (timingEv.drive)
      pendDrive_q <= 1'b0;
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      syncErr_q <= 1'b0;
    else if (!dcMode)
      syncErr_q <= 1'b0;
    else if (timingEv.sync0)
      syncErr_q <= pendDrive_q && !timingEv.drive;
  end

  assign errEv[0] = dcMode && timingEv.opState && timingEv.sync0
    && !smSeen_q && !timingEv.smEvent;
  assign errEv[1] = timingEv.opState && cycleStart && busy_q && !timingEv.cycleDone;
  assign errEv[2] = dcMode && timingEv.sync1 && s0s1Ns_q < meterNs[2];

  for (genvar g = 0; g < 3; g++)
  begin : gErr
    always_ff @(posedge core_clk or posedge rst)
    begin
      if (rst)
        errCnt_q[g] <= 16'h0000;
      else if (errEv[g] && errCnt_q[g] != `CNT_MAX)
        errCnt_q[g] <= errCnt_q[g] + 16'h0001;
    end
  end

  // Meters: 0 SYNC0 to drive, 1 cycle start to done, 2 event to drive, 3 SYNC1 to drive.
  assign mStart = {timingEv.sync1, timingEv.smEvent, cycleStart, timingEv.sync0};
  assign mStop = {timingEv.drive, timingEv.drive, timingEv.cycleDone, timingEv.drive};
  assign mEn = {dcMode, dcMode, 1'b1, dcMode} & {4{measuring_q}};

  for (genvar m = 0; m < 4; m++)
  begin : gMeter
    sync_interval_meter uMeter (
      .core_clk(core_clk),
      .rst(rst),
      .start(mStart[m]),
      .stop(mStop[m]),
      .enable(mEn[m]),
      .clear(startMeas),
      .maxNs(meterNs[m])
    );
  end

  always_comb
  begin
    rdData = 32'h0000_0000;
    rdOk = 1'b1;
    unique case ({s_axi_araddr[11:2], 2'h0})
      `OFF_SM_TYPE_CNT: rdData[7:0] = `RST_SM_TYPE_CNT;
      `OFF_SM_TYPE_CH1: rdData[7:0] = `RST_SM_TYPE_CH1;
      `OFF_SM_TYPE_CH2: rdData[7:0] = `RST_SM_TYPE_CH2;
      `OFF_SM_TYPE_CH3: rdData[7:0] = `RST_SM_TYPE_CH3;
      `OFF_SM_TYPE_CH4: rdData[7:0] = `RST_SM_TYPE_CH4;
      `OFF_RX_CNT: rdData[7:0] = `RST_RX_CNT;
      `OFF_RX_FIRST: rdData[15:0] = `RST_RX_FIRST;
      `OFF_RX_SECOND: rdData[15:0] = `RST_RX_SECOND;
      `OFF_TX_CNT: rdData[7:0] = `RST_TX_CNT;
      `OFF_TX_FIRST: rdData[15:0] = `RST_TX_FIRST;
      `OFF_TX_SECOND: rdData[15:0] = `RST_TX_SECOND;
      `OFF_TX_THIRD: rdData[15:0] = `RST_TX_THIRD;
      `OFF_TX_FOURTH: rdData[15:0] = `RST_TX_FOURTH;
      `OFF_SYSMAP_CNT: rdData[7:0] = `RST_SYSMAP_CNT;
      `OFF_SYSMAP_ENTRY: rdData = `RST_SYSMAP_ENTRY;
      `OFF_PAR_CNT: rdData[7:0] = `RST_PAR_CNT;
      `OFF_SYNC_MODE: rdData[15:0] = mode_q;
      `OFF_CYCLE_TIME: rdData = cycleTime_q;
      `OFF_SHIFT_TIME: rdData = meterNs[0];
      `OFF_MODES_SUP: rdData[15:0] = `RST_MODES_SUP;
      `OFF_MIN_CYCLE: rdData = meterNs[1];
      `OFF_CALC_COPY: rdData = meterNs[2];
      `OFF_MIN_DELAY: rdData = 32'h0000_0000;
      `OFF_MEAS_CMD: rdData[15:0] = cmd_q;
      `OFF_DELAY_TIME: rdData = meterNs[3];
      `OFF_MISSED_CNT: rdData[15:0] = errCnt_q[0];
      `OFF_OVERRUN_CNT: rdData[15:0] = errCnt_q[1];
      `OFF_SHORT_CNT: rdData[15:0] = errCnt_q[2];
      `OFF_SYNC_ERR: rdData[0] = syncErr_q;
      default: rdOk = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      arReady_q <= 1'b1;
      rValid_q <= 1'b0;
      rData_q <= 32'h0000_0000;
      rResp_q <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && arReady_q)
    begin
      arReady_q <= 1'b0;
      rValid_q <= 1'b1;
      rData_q <= rdData;
      rResp_q <= rdOk ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (rValid_q && s_axi_rready)
    begin
      arReady_q <= 1'b1;
      rValid_q <= 1'b0;
    end
  end

  chk_mode_store: assert property (@(posedge core_clk) disable iff (rst)
    (doWrite && awAddr_q == `OFF_SYNC_MODE && wStrb_q[1:0] == 2'h3
      && wData_q[15:1] == 15'h0000) |=> mode_q == $past(wData_q[15:0]))
    else $error("mode write not stored");
  chk_tick_free: assert property (@(posedge core_clk) disable iff (rst)
    tick_q |-> $past(mode_q) == sync_pkg::MODE_FREE && $past(cycleTime_q) != 32'h0000_0000)
    else $error("local tick outside free run");
  chk_modes_word: assert property (@(posedge core_clk) disable iff (rst)
    (s_axi_arvalid && arReady_q && s_axi_araddr == `OFF_MODES_SUP)
      |=> rValid_q && rData_q == 32'h0000_4001)
    else $error("supported modes word wrong");
  chk_cmd_run: assert property (@(posedge core_clk) disable iff (rst)
    wrCmd |=> measuring_q == $past(cmdNew[0]))
    else $error("command did not start or stop");
  chk_start_clears: assert property (@(posedge core_clk) disable iff (rst)
    startMeas |=> (meterNs[0] | meterNs[1] | meterNs[2] | meterNs[3])
      == 32'h0000_0000)
    else $error("maxima not cleared on start");
  chk_missed_step: assert property (@(posedge core_clk) disable iff (rst)
    (errEv[0] && errCnt_q[0] != `CNT_MAX) |=> errCnt_q[0] == $past(errCnt_q[0]) + 16'h0001)
    else $error("missed event not counted");
  chk_overrun_step: assert property (@(posedge core_clk) disable iff (rst)
    (timingEv.opState && cycleStart && busy_q && !timingEv.cycleDone
      && errCnt_q[1] != `CNT_MAX) |=> errCnt_q[1] == $past(errCnt_q[1]) + 16'h0001)
    else $error("cycle overrun not counted");
  chk_short_step: assert property (@(posedge core_clk) disable iff (rst)
    (!dcMode || !timingEv.sync1) |=> $stable(errCnt_q[2]))
    else $error("short counter moved without cause");
  chk_late_flag: assert property (@(posedge core_clk) disable iff (rst)
    (dcMode && timingEv.sync0 && $past(mode_q) == mode_q)
      |=> syncErr_q == $past(pendDrive_q && !timingEv.drive))
    else $error("sync error flag wrong");
  chk_count_sat: assert property (@(posedge core_clk) disable iff (rst)
    errCnt_q[1] == `CNT_MAX |=> errCnt_q[1] == `CNT_MAX)
    else $error("counter wrapped");
endmodule
`default_nettype wire

// *** dv/fieldbus_master_model.sv ***
// Fieldbus master model: steps the bank with frame events and clock pulses.
// Assumes the bench calls frame between register accesses, on core_clk.
`default_nettype none
module fieldbus_master_model (
  input wire logic core_clk,
  output sync_pkg::timing_evt_s ev
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ev = '0;
  // Pulses stay one cycle and drop back to zero when sh is 1 or more, so no stale strobe looks like a new event.
  task automatic frame(input int sh, input bit sm, input bit drv);
    @(posedge core_clk);
    ev.opState <= 1'b1;
    ev.smEvent <= sm;
    ev.sync0 <= 1'b1;
    for (int i = 0; i < sh; i++)
    begin
      @(posedge core_clk);
      ev.smEvent <= 1'b0;
      ev.sync0 <= 1'b0;
      ev.sync1 <= (i == 0 && sh > 1);
    end
    ev.drive <= drv;
    ev.cycleDone <= drv;
    @(posedge core_clk);
    ev.drive <= 1'b0;
    ev.cycleDone <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the output sync bank over AXI4-Lite with timing events.
// Assumes the fieldbus master model supplies the event strobes.
`default_nettype none
`include "sync_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, cycleTick, syncError;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v, base, w;
  logic [1:0] bresp, rresp, r;
  sync_pkg::timing_evt_s ev;
  int error_cnt = 0, compares = 0, cyc = 0, seed = 22941, s, n;
  logic [11:0] offs [22] = '{`OFF_SM_TYPE_CNT, `OFF_SM_TYPE_CH1, `OFF_SM_TYPE_CH2,
    `OFF_SM_TYPE_CH3, `OFF_SM_TYPE_CH4, `OFF_RX_CNT, `OFF_RX_FIRST, `OFF_RX_SECOND, `OFF_TX_CNT,
    `OFF_TX_FIRST, `OFF_TX_SECOND, `OFF_TX_THIRD, `OFF_TX_FOURTH, `OFF_SYSMAP_CNT,
    `OFF_SYSMAP_ENTRY, `OFF_PAR_CNT, `OFF_MODES_SUP, `OFF_SYNC_MODE, `OFF_CYCLE_TIME,
    `OFF_MIN_CYCLE, `OFF_OVERRUN_CNT, `OFF_SYNC_ERR};
  logic [31:0] exps [22] = '{32'h4, 32'h1, 32'h2, 32'h3, 32'h4, 32'h2, 32'h1603, 32'h1607,
    32'h4, 32'h1a00, 32'h1a01, 32'h1a02, 32'h1a03, 32'h1, 32'h60011140, 32'h20, 32'h4001,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] modes [5] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h22};

  sync_manager_output_timing i_dut (.core_clk(core_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .timingEv(ev), .cycleTick(cycleTick), .syncError(syncError));
  fieldbus_master_model i_master (.core_clk(core_clk), .ev(ev));

  initial
  begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // A hang is cut short well beyond the longest expected run.
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Expected interval for k clock edges between start and stop strobes.
  function automatic logic [31:0] ns_of(input int k);
    return k * `CLK_PERIOD_NS;
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] rs);
    @(posedge core_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(posedge core_clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        rs = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(posedge core_clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        rs = rresp;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    rd(a, v, r);
    chk($sformatf("reg %h", a), e, v);
    chk("rresp", 32'h0, {30'h0, r});
  endtask

  task automatic tick_gap(output int k);
    do @(posedge core_clk); while (cycleTick !== 1'b1);
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (cycleTick !== 1'b1);
  endtask

  initial
  begin
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    foreach (offs[i]) rdc(offs[i], exps[i]);
    $display("test reset values done");
    foreach (modes[i])
    begin
      wr(`OFF_SYNC_MODE, modes[i], r);
      rdc(`OFF_SYNC_MODE, modes[i]);
    end
    wr(`OFF_SYNC_MODE, 32'h5, r);
    rdc(`OFF_SYNC_MODE, 32'h22);
    wr(`OFF_MODES_SUP, 32'h0, r);
    chk("bresp", 32'h2, {30'h0, r});
    rdc(`OFF_MODES_SUP, 32'h4001);
    rd(12'hffc, v, r);
    chk("unmapped", 32'h2, {30'h0, r} | v);
    $display("test modes done");
    w = $random(seed);
    wr(`OFF_CYCLE_TIME, w, r);
    rdc(`OFF_CYCLE_TIME, w);
    n = 2 + ($random(seed) & 7);
    wr(`OFF_SYNC_MODE, 32'h0, r);
    wr(`OFF_CYCLE_TIME, 40 * n, r);
    tick_gap(s);
    chk("tick gap", n, s);
    wr(`OFF_CYCLE_TIME, 32'h0, r);
    $display("test free run done");
    s = 3 + ($random(seed) & 3);
    wr(`OFF_SYNC_MODE, 32'h2, r);
    wr(`OFF_MEAS_CMD, 32'h1, r);
    i_master.frame(s, 1'b1, 1'b1);
    rdc(`OFF_SHIFT_TIME, 40 * s);
    rdc(`OFF_DELAY_TIME, 40 * (s - 1));
    i_master.frame(2, 1'b1, 1'b1);
    rdc(`OFF_SHIFT_TIME, 40 * s);
    wr(`OFF_MEAS_CMD, 32'h0, r);
    i_master.frame(s + 2, 1'b1, 1'b1);
    rdc(`OFF_SHIFT_TIME, 40 * s);
    wr(`OFF_MEAS_CMD, 32'h1, r);
    rdc(`OFF_MEAS_CMD, 32'h1);
    rdc(`OFF_SHIFT_TIME, 32'h0);
    i_master.frame(2, 1'b1, 1'b1);
    rdc(`OFF_SHIFT_TIME, ns_of(2));
    rdc(`OFF_MIN_CYCLE, ns_of(2));
    rdc(`OFF_CALC_COPY, ns_of(2));
    rdc(`OFF_MIN_DELAY, 32'h0);
    rd(`OFF_SHORT_CNT, base, r);
    i_master.frame(2, 1'b1, 1'b1);
    rdc(`OFF_SHORT_CNT, base + 1);
    $display("test measurement done");
    rd(`OFF_MISSED_CNT, base, r);
    i_master.frame(2, 1'b0, 1'b1);
    i_master.frame(2, 1'b0, 1'b1);
    i_master.frame(2, 1'b1, 1'b1);
    rdc(`OFF_MISSED_CNT, base + 2);
    rd(`OFF_OVERRUN_CNT, base, r);
    i_master.frame(2, 1'b1, 1'b0);
    i_master.frame(2, 1'b1, 1'b1);
    chk("syncError", 32'h1, {31'h0, syncError});
    rdc(`OFF_SYNC_ERR, 32'h1);
    i_master.frame(2, 1'b1, 1'b1);
    chk("syncError", 32'h0, {31'h0, syncError});
    rdc(`OFF_OVERRUN_CNT, base + 1);
    $display("test error counters done");
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    rdc(`OFF_OVERRUN_CNT, 32'h0);
    rdc(`OFF_SYNC_MODE, `RST_SYNC_MODE);
    $display("test reset again done");
    end_of_test();
  end
endmodule
`default_nettype wire

// *** inc/sync_map.svh ***
// Offsets, reset values, field positions and timing counts of the output sync bank.
// Assumes a 25 MHz core clock and a 32-bit AXI4-Lite register bus.
`ifndef SYNC_MAP_SVH
`define SYNC_MAP_SVH
`define CLK_PERIOD_NS 32'h0000_0028
`define NS_SAT_LIMIT (32'hffff_ffff - `CLK_PERIOD_NS)
`define OFF_SM_TYPE_CNT 12'h000
`define OFF_SM_TYPE_CH1 12'h004
`define OFF_SM_TYPE_CH2 12'h008
`define OFF_SM_TYPE_CH3 12'h00c
`define OFF_SM_TYPE_CH4 12'h010
`define OFF_RX_CNT 12'h020
`define OFF_RX_FIRST 12'h024
`define OFF_RX_SECOND 12'h028
`define OFF_TX_CNT 12'h030
`define OFF_TX_FIRST 12'h034
`define OFF_TX_SECOND 12'h038
`define OFF_TX_THIRD 12'h03c
`define OFF_TX_FOURTH 12'h040
`define OFF_SYSMAP_CNT 12'h050
`define OFF_SYSMAP_ENTRY 12'h054
`define OFF_PAR_CNT 12'h100
`define OFF_SYNC_MODE 12'h104
`define OFF_CYCLE_TIME 12'h108
`define OFF_SHIFT_TIME 12'h10c
`define OFF_MODES_SUP 12'h110
`define OFF_MIN_CYCLE 12'h114
`define OFF_CALC_COPY 12'h118
`define OFF_MIN_DELAY 12'h11c
`define OFF_MEAS_CMD 12'h120
`define OFF_DELAY_TIME 12'h124
`define OFF_MISSED_CNT 12'h12c
`define OFF_OVERRUN_CNT 12'h130
`define OFF_SHORT_CNT 12'h134
`define OFF_SYNC_ERR 12'h180
`define RST_SM_TYPE_CNT 8'h04
`define RST_SM_TYPE_CH1 8'h01
`define RST_SM_TYPE_CH2 8'h02
`define RST_SM_TYPE_CH3 8'h03
`define RST_SM_TYPE_CH4 8'h04
`define RST_RX_CNT 8'h02
`define RST_RX_FIRST 16'h1603
`define RST_RX_SECOND 16'h1607
`define RST_TX_CNT 8'h04
`define RST_TX_FIRST 16'h1a00
`define RST_TX_SECOND 16'h1a01
`define RST_TX_THIRD 16'h1a02
`define RST_TX_FOURTH 16'h1a03
`define RST_SYSMAP_CNT 8'h01
`define RST_SYSMAP_ENTRY 32'h6001_1140
`define RST_PAR_CNT 8'h20
`define RST_SYNC_MODE 16'h0000
`define RST_CYCLE_TIME 32'h0000_0000
`define RST_MODES_SUP 16'h4001
`define RST_MEAS_CMD 16'h0000
`define CMD_START_BIT 0
`define CNT_MAX 16'hffff
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// *** inc/sync_pkg.sv ***
// Types shared by the output sync bank, the fieldbus master model and the bench.
// Assumes the event strobes come from logic on the core clock.
`default_nettype none
package sync_pkg;
  typedef enum logic [15:0] {
    MODE_FREE = 16'h0000,
    MODE_SM = 16'h0001,
    MODE_DC_S0 = 16'h0002,
    MODE_DC_S1 = 16'h0003,
    MODE_SM_OUT = 16'h0022
  } sync_mode_e;
  typedef struct packed {
    logic smEvent;
    logic sync0;
    logic sync1;
    logic drive;
    logic cycleDone;
    logic opState;
  } timing_evt_s;
endpackage
`default_nettype wire
